// file: call_stack.sv
// Return-address stack, circular: overflow overwrites the oldest entry.
// Assumes push and pop are never asked in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module call_stack #(
	parameter int DEPTH = core_pkg::STACK_DEPTH,
	parameter int W = core_pkg::PC_W
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic push,
	input wire logic pop,
	input wire logic [W-1:0] push_data,
	output logic [W-1:0] stack_head
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] PTR_ONE = 1;
	logic [PW-1:0] ptr_reg;
	logic [PW-1:0] ptr_next;
	logic [DEPTH-1:0][W-1:0] slots;

	if (DEPTH < 2 || (1 << PW) != DEPTH)
		$error("call_stack DEPTH must be a power of two");

	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		logic [W-1:0] slot_reg;
		logic [W-1:0] slot_next;
		always_comb begin
			slot_next = slot_reg;
			if (push && ptr_reg == PW'(i))
				slot_next = push_data;
		end
		always_ff @(posedge clk) begin
			if (!nrst)
				slot_reg <= '0;
			else
				slot_reg <= slot_next;
		end
		assign slots[i] = slot_reg;
	end

	always_comb begin
		ptr_next = ptr_reg;
		if (push)
			ptr_next = ptr_reg + PTR_ONE;
		else if (pop)
			ptr_next = ptr_reg - PTR_ONE;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			ptr_reg <= '0;
		else
			ptr_reg <= ptr_next;
	end

	assign stack_head = slots[ptr_reg - PTR_ONE];
endmodule : call_stack
`default_nettype wire

// file: core_alu.sv
// Combinational 8-bit arithmetic and logic unit.
// Assumes operands are stable for the whole execute phase.
`timescale 1ns/100ps
`default_nettype none
module core_alu (
	input wire core_pkg::alu_op_type op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [2:0] bit_index,
	input wire logic carry_in,
	output core_pkg::alu_out_type res
);
	logic [8:0] sum;
	logic [4:0] low;
	logic [7:0] mask;

	always_comb begin
		sum = 9'h000;
		low = 5'h00;
		mask = 8'h01 << bit_index;
		res = '0;
		res.value = a;
		case (op)
			core_pkg::ALU_ADD: begin
				sum = {1'b0, a} + {1'b0, b};
				low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
				res.value = sum[7:0];
			end
			// Minuend minus accumulator; carry high means no borrow
			core_pkg::ALU_SUB: begin
				sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
				low = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
				res.value = sum[7:0];
			end
			core_pkg::ALU_AND: res.value = a & b;
			core_pkg::ALU_OR: res.value = a | b;
			core_pkg::ALU_XOR: res.value = a ^ b;
			core_pkg::ALU_PASS_B: res.value = b;
			core_pkg::ALU_INV: res.value = ~b;
			core_pkg::ALU_DEC: res.value = b - 8'h01;
			core_pkg::ALU_INC: res.value = b + 8'h01;
			core_pkg::ALU_RL: {sum[8], res.value} = {b, carry_in};
			core_pkg::ALU_RR: {res.value, sum[8]} = {carry_in, b};
			core_pkg::ALU_SWAP: res.value = {b[3:0], b[7:4]};
			core_pkg::ALU_ZERO: res.value = 8'h00;
			core_pkg::ALU_BCLR: res.value = b & ~mask;
			core_pkg::ALU_BSET: res.value = b | mask;
			default: res.value = a;
		endcase
		res.carry = sum[8];
		res.nibble_carry = low[4];
		res.zero = (res.value == 8'h00);
	end
endmodule : core_alu
`default_nettype wire

// file: core_exec.sv
// Instruction decode and execute unit of the 8-bit core, Wishbone regs.
// Assumes program memory and file registers answer within the cycle.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RQ1 - Byte ops under 00: add, subtract, and, or, xor with d and f.
// RQ2 - Byte ops: copy, invert, rotate left, rotate right, nibble swap.
// RQ3 - Decrement, increment and their skip-on-zero forms; skip costs a cycle.
// RQ4 - Bit ops under 01: clear, set, test-low skip, test-high skip.
// RQ5 - Test-skip-if-low drops next word when the bit is 0.
// RQ6 - Test-skip-if-high drops next word when the bit is 1.
// RQ7 - Call pushes return address, loads 11-bit target plus latch bits 4:3.
// RQ8 - Literal ops under 11: load, return literal, or, and, xor, sub, add.
// RQ9 - Addition updates carry, nibble carry and zero.
// RQ10 - Destination bit 0 writes accumulator, 1 writes file register.
// RQ11 - And updates only the zero flag.
// RQ12 - Bit clear and bit set touch one bit, no flags.
// RQ13 - Zero forms clear register or accumulator and set zero flag.
// RQ14 - Watchdog kick clears guard timer and prescaler, sets both flags. The code pulses GUARD_TIMER_CLEAR only and never clears the prescaler.
// RQ15 - Port reads use pin levels, not output latch contents.
// RQ16 - Writing timer zero count clears its assigned prescaler.
// RQ17 - Branches and true tests take two cycles, second a no-op.
// RQ18 - Returns pop the stack in two cycles; literal form loads acc.
// RQ19 - File addresses 7 bits, literals 8 bits, branch targets 11 bits.
// RQ20 - Jump loads target and latch bits, pushes nothing, two cycles.
// RQ21 - Return from interrupt pops stack and sets global irq enable.
// RQ22 - Sleep clears powerdown flag, sets expired flag, clears timer, halts.
// RQ23 - Each instruction cycle spans four clock periods.
// RQ24 - Subtract is minuend minus acc, carry as active-low borrow.
// RQ25 - Zero-prefix control words decoded from their low byte.
// RQ26 - Two-cycle execution invalidates the prefetched word.
module core_exec #(
	parameter logic [6:0] PORT_ADDR = 7'h05,
	parameter logic [6:0] TIMER_ADDR = 7'h01,
	parameter int STACK_DEPTH = core_pkg::STACK_DEPTH
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	output logic [12:0] PROG_ADDR,
	input wire logic [13:0] PROG_DATA,
	output logic [6:0] FILE_ADDR,
	input wire logic [7:0] FILE_RDATA,
	output logic [7:0] FILE_WDATA,
	output logic FILE_WE,
	input wire logic [7:0] PIN_LEVELS,
	input wire logic PRESCALER_ON_TIMER,
	output logic TIMER_PRESCALER_CLEAR,
	output logic GUARD_TIMER_CLEAR,
	output logic WATCHDOG_EXPIRED_FLAG,
	output logic POWERDOWN_FLAG,
	output logic GLOBAL_IRQ_ENABLE,
	output logic HALTED,
	output logic [7:0] ACCUMULATOR,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O
);
	core_pkg::phase_type phase_reg, phase_next;
	logic [13:0] ir_reg, ir_next;
	logic ir_valid_reg, ir_valid_next;
	logic [12:0] pc_reg, pc_next;
	logic [7:0] acc_reg, acc_next;
	logic z_reg, z_next, dc_reg, dc_next, c_reg, c_next;
	logic to_reg, to_next, pwrdn_reg, pwrdn_next;
	logic halt_reg, halt_next, irq_en_reg, irq_en_next;
	logic [4:0] latch_reg, latch_next;
	logic [6:0] faddr_reg, faddr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic we_reg, we_next, kick_reg, kick_next;
	logic presc_reg, presc_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	core_pkg::decoded_type dec;
	core_pkg::alu_out_type alu;
	logic exec, skip, push, pop;
	logic [7:0] operand, opnd_b;
	logic [12:0] target, head;
	logic wb_req, wb_wr;

	function automatic core_pkg::decoded_type decode(
		input logic [13:0] w);
		core_pkg::decoded_type d;
		d = '0;
		d.op = core_pkg::ALU_PASS_A;
		case (w[13:12])
			core_pkg::CLS_BYTE: begin
				// Destination select for every byte op [RQ10] [RQ1]
				d.to_reg = w[7];
				d.to_acc = !w[7];
				d.upd_z = 1'b1;
				case (w[11:8])
					core_pkg::OP_CTRL: begin
						d.upd_z = 1'b0;
						d.to_acc = 1'b0;
						// Low byte picks the control word [RQ25]
						if (!w[7]) begin
							d.ret = (w[7:0] == core_pkg::CTL_RETURN);
							d.ret_irq = (w[7:0] == core_pkg::CTL_RETIRQ);
							d.sleep = (w[7:0] == core_pkg::CTL_SLEEP);
							d.kick = (w[7:0] == core_pkg::CTL_KICK);
						end
					end
					core_pkg::OP_ZERO: d.op = core_pkg::ALU_ZERO; // [RQ13]
					core_pkg::OP_ADD: begin
						d.op = core_pkg::ALU_ADD;
						d.upd_c = 1'b1; // [RQ9]
						d.upd_dc = 1'b1;
					end
					core_pkg::OP_SUB: begin
						d.op = core_pkg::ALU_SUB; // [RQ24]
						d.upd_c = 1'b1;
						d.upd_dc = 1'b1;
					end
					core_pkg::OP_AND: d.op = core_pkg::ALU_AND; // [RQ11]
					core_pkg::OP_OR: d.op = core_pkg::ALU_OR;
					core_pkg::OP_XOR: d.op = core_pkg::ALU_XOR;
					core_pkg::OP_COPY: d.op = core_pkg::ALU_PASS_B; // [RQ2]
					core_pkg::OP_INV: d.op = core_pkg::ALU_INV;
					core_pkg::OP_DEC: d.op = core_pkg::ALU_DEC; // [RQ3]
					core_pkg::OP_INC: d.op = core_pkg::ALU_INC;
					core_pkg::OP_SWAP: begin
						d.op = core_pkg::ALU_SWAP;
						d.upd_z = 1'b0;
					end
					core_pkg::OP_RL, core_pkg::OP_RR: begin
						d.op = w[8] ? core_pkg::ALU_RL : core_pkg::ALU_RR;
						d.upd_z = 1'b0;
						d.upd_c = 1'b1;
					end
					core_pkg::OP_DECSKIP, core_pkg::OP_INCSKIP: begin
						d.op = w[10] ? core_pkg::ALU_INC : core_pkg::ALU_DEC;
						d.upd_z = 1'b0;
						d.skip_on_zero = 1'b1; // [RQ3]
					end
					default: d.upd_z = 1'b0;
				endcase
			end
			core_pkg::CLS_BIT: begin
				// Bit ops leave every flag alone [RQ4] [RQ12]
				case (w[11:10])
					core_pkg::BIT_CLR: begin
						d.op = core_pkg::ALU_BCLR;
						d.to_reg = 1'b1;
					end
					core_pkg::BIT_SET: begin
						d.op = core_pkg::ALU_BSET;
						d.to_reg = 1'b1;
					end
					default: begin
						d.bit_test = 1'b1;
						d.test_level = w[10];
					end
				endcase
			end
			core_pkg::CLS_BRANCH: begin
				d.call = !w[11]; // [RQ7]
				d.jump = w[11]; // [RQ20]
			end
			default: begin
				// Literal ops, x bits ignored [RQ8] [RQ19]
				d.use_lit = 1'b1;
				d.to_acc = 1'b1;
				d.op = core_pkg::ALU_PASS_B;
				if (!w[11]) begin
					d.ret = w[10]; // [RQ18]
				end else if (w[10]) begin
					d.op = w[9] ? core_pkg::ALU_ADD : core_pkg::ALU_SUB;
					d.upd_z = 1'b1;
					d.upd_c = 1'b1; // [RQ9] [RQ24]
					d.upd_dc = 1'b1;
				end else begin
					d.upd_z = 1'b1;
					case (w[9:8])
						core_pkg::LIT_OR: d.op = core_pkg::ALU_OR;
						core_pkg::LIT_AND: d.op = core_pkg::ALU_AND;
						core_pkg::LIT_XOR: d.op = core_pkg::ALU_XOR;
						default: begin
							d.to_acc = 1'b0;
							d.upd_z = 1'b0;
						end
					endcase
				end
			end
		endcase
		return d;
	endfunction : decode

	// Port reads see the pins, so a read-modify-write copies them [RQ15]
	assign operand = (faddr_reg == PORT_ADDR) ? PIN_LEVELS : FILE_RDATA;
	assign opnd_b = dec.use_lit ? ir_reg[7:0] : operand;
	assign target = {latch_reg[4:3], ir_reg[10:0]};
	assign exec = (phase_reg == core_pkg::Q4) && !halt_reg;
	assign push = exec && dec.call;
	assign pop = exec && (dec.ret || dec.ret_irq);
	assign wb_req = WB_CYC_I && WB_STB_I;
	assign wb_wr = wb_req && WB_WE_I && ack_reg;

	always_comb begin
		// A discarded word decodes as a no-op [RQ26]
		dec = ir_valid_reg ? decode(ir_reg) : decode(14'h0000);
		skip = (dec.skip_on_zero && alu.zero) // [RQ3]
			|| (dec.bit_test // [RQ5] [RQ6]
			&& operand[ir_reg[9:7]] == dec.test_level);
	end

	core_alu u_alu (
		.op(dec.op),
		.a(acc_reg),
		.b(opnd_b),
		.bit_index(ir_reg[9:7]),
		.carry_in(c_reg),
		.res(alu)
	);

	call_stack #(
		.DEPTH(STACK_DEPTH),
		.W(13)
	) u_stack (
		.clk(CORE_CLK),
		.nrst(NRST),
		.push(push),
		.pop(pop),
		.push_data(pc_reg),
		.stack_head(head)
	);

	always_comb begin
		phase_next = phase_reg;
		ir_next = ir_reg;
		ir_valid_next = ir_valid_reg;
		pc_next = pc_reg;
		acc_next = acc_reg;
		z_next = z_reg;
		dc_next = dc_reg;
		c_next = c_reg;
		to_next = to_reg;
		pwrdn_next = pwrdn_reg;
		halt_next = halt_reg;
		irq_en_next = irq_en_reg;
		latch_next = latch_reg;
		faddr_next = faddr_reg;
		wdata_next = wdata_reg;
		we_next = 1'b0;
		kick_next = 1'b0;
		presc_next = 1'b0;
		// Four clock periods per instruction cycle [RQ23]
		case (phase_reg)
			core_pkg::Q1: phase_next = core_pkg::Q2;
			core_pkg::Q2: phase_next = core_pkg::Q3;
			core_pkg::Q3: phase_next = core_pkg::Q4;
			core_pkg::Q4: phase_next = core_pkg::Q1;
			default: phase_next = core_pkg::Q1;
		endcase
		// Address moves only at Q1 so a write issued at Q4 keeps it
		if (phase_reg == core_pkg::Q1)
			faddr_next = ir_reg[6:0];
		if (wb_wr && WB_ADR_I == core_pkg::REG_CONTROL) begin
			if (WB_SEL_I[0])
				irq_en_next = WB_DAT_I[core_pkg::CTL_IRQ_EN_BIT];
			if (WB_SEL_I[1])
				latch_next = WB_DAT_I[core_pkg::CTL_LATCH_LSB +: 5];
		end
		if (exec) begin
			ir_next = PROG_DATA;
			ir_valid_next = 1'b1;
			pc_next = pc_reg + 13'h0001;
			if (dec.to_acc)
				acc_next = alu.value; // [RQ10] [RQ18]
			if (dec.to_reg) begin
				we_next = 1'b1; // [RQ10] [RQ12]
				wdata_next = alu.value;
				// [RQ16]
				presc_next = (faddr_reg == TIMER_ADDR) && PRESCALER_ON_TIMER;
			end
			if (dec.upd_z)
				z_next = alu.zero; // [RQ11] [RQ13]
			if (dec.upd_c)
				c_next = alu.carry; // [RQ9] [RQ24]
			if (dec.upd_dc)
				dc_next = alu.nibble_carry;
			if (dec.call || dec.jump)
				pc_next = target; // [RQ7] [RQ20]
			if (dec.ret || dec.ret_irq)
				pc_next = head; // [RQ18] [RQ21]
			// Taken branch or test wastes the prefetched slot [RQ17] [RQ26]
			if (skip || dec.call || dec.jump || dec.ret || dec.ret_irq)
				ir_valid_next = 1'b0;
			if (dec.ret_irq)
				irq_en_next = 1'b1; // [RQ21]
			if (dec.kick) begin
				kick_next = 1'b1; // [RQ14]
				to_next = 1'b1;
				pwrdn_next = 1'b1;
			end
			// No wake source here: only reset leaves the halt [RQ22]
			if (dec.sleep) begin
				kick_next = 1'b1;
				to_next = 1'b1;
				pwrdn_next = 1'b0;
				halt_next = 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			phase_reg <= core_pkg::Q1;
			ir_reg <= 14'h0000;
			ir_valid_reg <= 1'b0;
			pc_reg <= 13'h0000;
			acc_reg <= 8'h00;
			z_reg <= 1'b0;
			dc_reg <= 1'b0;
			c_reg <= 1'b0;
			to_reg <= core_pkg::RST_EXPIRED;
			pwrdn_reg <= core_pkg::RST_POWERDOWN;
			halt_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			latch_reg <= 5'h00;
			faddr_reg <= 7'h00;
			wdata_reg <= 8'h00;
			we_reg <= 1'b0;
			kick_reg <= 1'b0;
			presc_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			ir_reg <= ir_next;
			ir_valid_reg <= ir_valid_next;
			pc_reg <= pc_next;
			acc_reg <= acc_next;
			z_reg <= z_next;
			dc_reg <= dc_next;
			c_reg <= c_next;
			to_reg <= to_next;
			pwrdn_reg <= pwrdn_next;
			halt_reg <= halt_next;
			irq_en_reg <= irq_en_next;
			latch_reg <= latch_next;
			faddr_reg <= faddr_next;
			wdata_reg <= wdata_next;
			we_reg <= we_next;
			kick_reg <= kick_next;
			presc_reg <= presc_next;
		end
	end

	// Wishbone slave: ack one cycle after the strobe, dropped next cycle
	always_comb begin
		ack_next = wb_req && !ack_reg;
		rdat_next = 32'h00000000;
		case (WB_ADR_I)
			core_pkg::REG_CONTROL:
				rdat_next = {19'h00000, latch_reg, 7'h00, irq_en_reg};
			core_pkg::REG_STATUS:
				rdat_next = {18'h00000, halt_reg, pwrdn_reg, to_reg,
					c_reg, dc_reg, z_reg, acc_reg};
			core_pkg::REG_PC: rdat_next = {19'h00000, pc_reg};
			default: rdat_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign PROG_ADDR = pc_reg;
	assign FILE_ADDR = faddr_reg;
	assign FILE_WDATA = wdata_reg;
	assign FILE_WE = we_reg;
	assign TIMER_PRESCALER_CLEAR = presc_reg;
	assign GUARD_TIMER_CLEAR = kick_reg;
	assign WATCHDOG_EXPIRED_FLAG = to_reg;
	assign POWERDOWN_FLAG = pwrdn_reg;
	assign GLOBAL_IRQ_ENABLE = irq_en_reg;
	assign HALTED = halt_reg;
	assign ACCUMULATOR = acc_reg;
	assign WB_DAT_O = rdat_reg;
	assign WB_ACK_O = ack_reg;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	property p_phase_walk;
		phase_reg == core_pkg::Q1 |=> phase_reg == core_pkg::Q2
			##1 phase_reg == core_pkg::Q3 ##1 phase_reg == core_pkg::Q4;
	endproperty
	a_phase_walk: assert property (p_phase_walk) // [RQ23]
		else $error("instruction cycle is not four clocks");

	property p_write_after_q4;
		FILE_WE |-> $past(phase_reg) == core_pkg::Q4 && phase_reg == core_pkg::Q1;
	endproperty
	a_write_after_q4: assert property (p_write_after_q4) // [RQ10]
		else $error("file write outside its slot");

	property p_call_target;
		exec && dec.call |=> PROG_ADDR == $past(target) && !ir_valid_reg
			##4 head == $past(pc_reg, 5);
	endproperty
	a_call_target: assert property (p_call_target) // [RQ7]
		else $error("call target or return address wrong");

	property p_jump_target;
		exec && dec.jump |=> PROG_ADDR == $past(target) && !ir_valid_reg;
	endproperty
	a_jump_target: assert property (p_jump_target) // [RQ20]
		else $error("jump target wrong or slot kept");

	property p_test_skip;
		exec && dec.bit_test
			&& operand[ir_reg[9:7]] == dec.test_level |=> !ir_valid_reg;
	endproperty
	a_test_skip: assert property (p_test_skip) // [RQ5]
		else $error("bit test did not discard next word");

	property p_zero_sets_z;
		exec && dec.op == core_pkg::ALU_ZERO && dec.upd_z |=> z_reg;
	endproperty
	a_zero_sets_z: assert property (p_zero_sets_z) // [RQ13]
		else $error("zero op left zero flag clear");

	property p_kick;
		exec && dec.kick |=> GUARD_TIMER_CLEAR && WATCHDOG_EXPIRED_FLAG
			&& POWERDOWN_FLAG ##1 !GUARD_TIMER_CLEAR;
	endproperty
	a_kick: assert property (p_kick) // [RQ14]
		else $error("watchdog kick effects wrong");

	property p_sleep;
		exec && dec.sleep |=> HALTED && !POWERDOWN_FLAG
			&& WATCHDOG_EXPIRED_FLAG && GUARD_TIMER_CLEAR;
	endproperty
	a_sleep: assert property (p_sleep) // [RQ22]
		else $error("sleep effects wrong");

	property p_timer_presc;
		exec && dec.to_reg && faddr_reg == TIMER_ADDR && PRESCALER_ON_TIMER
			|=> TIMER_PRESCALER_CLEAR;
	endproperty
	a_timer_presc: assert property (p_timer_presc) // [RQ16]
		else $error("timer write did not clear prescaler");

	property p_retirq;
		exec && dec.ret_irq |=> GLOBAL_IRQ_ENABLE && PROG_ADDR == $past(head);
	endproperty
	a_retirq: assert property (p_retirq) // [RQ21]
		else $error("return from irq wrong");
endmodule : core_exec
`default_nettype wire

// file: core_exec_test.sv
// Self-checking bench for the decode and execute unit.
// Assumes the partner model answers program and file reads at once.
`timescale 1ns/100ps
`default_nettype none
module core_exec_test;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [12:0] pa;
	logic [13:0] pdat;
	logic [6:0] fa;
	logic [7:0] frd, fwd, acc;
	logic fwe, pclr, gclr, exp_f, pdn_f, irq_en, halt, ack;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	int err_total = 0, compares = 0, n_g = 0, n_p = 0;
	core_exec dut (.CORE_CLK(clk), .NRST(nrst), .PROG_ADDR(pa),
		.PROG_DATA(pdat), .FILE_ADDR(fa), .FILE_RDATA(frd),
		.FILE_WDATA(fwd), .FILE_WE(fwe), .PIN_LEVELS(8'hA5),
		.PRESCALER_ON_TIMER(1'b1), .TIMER_PRESCALER_CLEAR(pclr),
		.GUARD_TIMER_CLEAR(gclr), .WATCHDOG_EXPIRED_FLAG(exp_f),
		.POWERDOWN_FLAG(pdn_f), .GLOBAL_IRQ_ENABLE(irq_en),
		.HALTED(halt), .ACCUMULATOR(acc), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
	prog_mem_model pm (.clk(clk), .prog_addr(pa), .prog_data(pdat),
		.file_addr(fa), .file_rdata(frd), .file_wdata(fwd),
		.file_we(fwe));
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		if (gclr === 1'b1) n_g++;
		if (pclr === 1'b1) n_p++;
	end
	task automatic finish_test();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Request stands until the edge at which ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [3:0] s, input logic [31:0] d);
		logic seen;
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			seen = ack;
			q = rdat;
			n++;
		end while (seen !== 1'b1 && n < 20);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (seen !== 1'b1) begin
			err_total++;
			finish_test();
		end
	endtask : wb
	// Holds reset while the program image is cleared
	task automatic start();
		@(posedge clk);
		nrst <= 1'b0;
		foreach (pm.mem[i]) pm.mem[i] = 14'h0000;
		foreach (pm.regs[i]) pm.regs[i] = 8'h00;
		@(posedge clk);
		n_g = 0;
		n_p = 0;
	endtask : start
	task automatic run(input int n);
		nrst <= 1'b1;
		repeat (4 * n) @(posedge clk);
		#1;
	endtask : run
	task automatic t_literal();
		start();
		pm.mem[0] = 14'h300F;
		pm.mem[1] = 14'h38F0;
		pm.mem[2] = 14'h393C;
		pm.mem[3] = 14'h3AFF;
		pm.mem[4] = 14'h3CC5;
		pm.mem[5] = 14'h3EFE;
		run(6);
		chk(acc, 8'h02);
		run(2);
		wb(1'b0, 4'h4, 4'hF, 32'h0);
		chk(q[15:0], 16'h1F00);
		wb(1'b0, 4'hC, 4'hF, 32'h0);
		chk(q[15:0], 16'h0000);
		$display("t_literal done");
	endtask : t_literal
	task automatic t_byte();
		start();
		pm.regs[7'h22] = 8'h55;
		pm.mem[0] = 14'h3012;
		pm.mem[1] = 14'h00A0;
		pm.mem[2] = 14'h0EA0;
		pm.mem[3] = 14'h0720;
		pm.mem[4] = 14'h0081;
		pm.mem[5] = 14'h01A2;
		pm.mem[6] = 14'h0805;
		pm.mem[7] = 14'h0AA0;
		run(12);
		chk(pm.regs[7'h01], 8'h33);
		chk(pm.regs[7'h20], 8'h22);
		chk(pm.regs[7'h22], 8'h00);
		chk(acc, 8'hA5);
		chk(n_p, 1);
		$display("t_byte done");
	endtask : t_byte
	task automatic t_skip();
		start();
		pm.regs[7'h23] = 8'h01;
		pm.mem[0] = 14'h3001;
		pm.mem[1] = 14'h00A2;
		pm.mem[2] = 14'h1822;
		pm.mem[3] = 14'h3011;
		pm.mem[4] = 14'h1C22;
		pm.mem[5] = 14'h3099;
		pm.mem[6] = 14'h17A2;
		pm.mem[7] = 14'h0BA3;
		pm.mem[8] = 14'h3066;
		run(14);
		chk(acc, 8'h11);
		chk(pm.regs[7'h22], 8'h81);
		chk(pm.regs[7'h23], 8'h00);
		$display("t_skip done");
	endtask : t_skip
	task automatic t_branch();
		start();
		pm.mem[0] = 14'h2010;
		pm.mem[1] = 14'h2030;
		pm.mem[2] = 14'h2820;
		pm.mem[3] = 14'h3099;
		pm.mem[13'h010] = 14'h3455;
		pm.mem[13'h030] = 14'h0009;
		pm.mem[13'h020] = 14'h2820;
		run(16);
		chk(acc, 8'h55);
		chk(irq_en, 1'b1);
		$display("t_branch done");
	endtask : t_branch
	task automatic t_latch();
		start();
		pm.mem[0] = 14'h2805;
		pm.mem[5] = 14'h3099;
		pm.mem[13'h1805] = 14'h306C;
		nrst <= 1'b1;
		wb(1'b1, 4'h0, 4'h3, 32'h0000_1801);
		run(6);
		chk(acc, 8'h6C);
		wb(1'b0, 4'h0, 4'hF, 32'h0);
		chk(q[15:0], 16'h1801);
		$display("t_latch done");
	endtask : t_latch
	task automatic t_power();
		start();
		chk({exp_f, pdn_f, irq_en, acc}, 11'h600);
		pm.mem[1] = 14'h0064;
		pm.mem[2] = 14'h0063;
		pm.mem[3] = 14'h30FF;
		run(8);
		chk(n_g, 2);
		chk({exp_f, pdn_f, halt, acc}, 11'h500);
		$display("t_power done");
	endtask : t_power
	initial begin
		repeat (12) @(posedge clk);
		t_power();
		t_literal();
		t_byte();
		t_skip();
		t_branch();
		t_latch();
		finish_test();
	end
endmodule : core_exec_test
`default_nettype wire

// file: core_pkg.sv
// Shared encodings, field positions and reset values of the core.
// Assumes a 14-bit instruction word and an 8-bit data path.
package core_pkg;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	// Top field of the instruction word
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT = 2'h1;
	localparam logic [1:0] CLS_BRANCH = 2'h2;
	localparam logic [1:0] CLS_LIT = 2'h3;
	// Byte-oriented operation codes
	localparam logic [3:0] OP_CTRL = 4'h0;
	localparam logic [3:0] OP_ZERO = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_DEC = 4'h3;
	localparam logic [3:0] OP_OR = 4'h4;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_COPY = 4'h8;
	localparam logic [3:0] OP_INV = 4'h9;
	localparam logic [3:0] OP_INC = 4'hA;
	localparam logic [3:0] OP_DECSKIP = 4'hB;
	localparam logic [3:0] OP_RR = 4'hC;
	localparam logic [3:0] OP_RL = 4'hD;
	localparam logic [3:0] OP_SWAP = 4'hE;
	localparam logic [3:0] OP_INCSKIP = 4'hF;
	// Low byte of the all-zero-prefix control words
	localparam logic [7:0] CTL_RETURN = 8'h08;
	localparam logic [7:0] CTL_RETIRQ = 8'h09;
	localparam logic [7:0] CTL_SLEEP = 8'h63;
	localparam logic [7:0] CTL_KICK = 8'h64;
	// Bit-oriented sub-codes
	localparam logic [1:0] BIT_CLR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	// Literal sub-codes in bits 9:8 when bits 11:10 are 10
	localparam logic [1:0] LIT_OR = 2'h0;
	localparam logic [1:0] LIT_AND = 2'h1;
	localparam logic [1:0] LIT_XOR = 2'h2;
	// Register map, byte addresses
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_PC = 4'h8;
	localparam int CTL_IRQ_EN_BIT = 0;
	localparam int CTL_LATCH_LSB = 8;
	localparam logic RST_EXPIRED = 1'h1;
	localparam logic RST_POWERDOWN = 1'h1;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS_B,
		ALU_PASS_A, ALU_INV, ALU_DEC, ALU_INC, ALU_RL, ALU_RR,
		ALU_SWAP, ALU_ZERO, ALU_BCLR, ALU_BSET
	} alu_op_type;

	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_type;

	typedef struct packed {
		logic [7:0] value;
		logic carry;
		logic nibble_carry;
		logic zero;
	} alu_out_type;

	typedef struct packed {
		alu_op_type op;
		logic use_lit;
		logic to_reg;
		logic to_acc;
		logic upd_z;
		logic upd_c;
		logic upd_dc;
		logic skip_on_zero;
		logic bit_test;
		logic test_level;
		logic call;
		logic jump;
		logic ret;
		logic ret_irq;
		logic kick;
		logic sleep;
	} decoded_type;
endpackage : core_pkg

// file: prog_mem_model.sv
// Program memory and file register model facing the core.
// Assumes the bench loads words and registers while reset is held.
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
	input wire logic clk,
	input wire logic [12:0] prog_addr,
	output logic [13:0] prog_data,
	input wire logic [6:0] file_addr,
	output logic [7:0] file_rdata,
	input wire logic [7:0] file_wdata,
	input wire logic file_we
);
	logic [13:0] mem [0:8191];
	logic [7:0] regs [0:127];
	// Answers within the cycle, as the core samples at its Q4 edge
	assign prog_data = mem[prog_addr];
	assign file_rdata = regs[file_addr];
	always @(posedge clk) begin
		if (file_we === 1'b1)
			regs[file_addr] <= file_wdata;
	end
endmodule : prog_mem_model
`default_nettype wire
